// ### common/rffc_pkg.sv
// Shared constants, register map and mode codes for the RF front-end control block.
package rffc_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_FREQ_MHZ = 200;
	localparam int LEAD_UNIT_US = 1;
	localparam int CYC_PER_US = LEAD_UNIT_US * CLK_FREQ_MHZ;
	localparam logic [8:0] LEAD_MIN_US = 9'h001;
	localparam logic [8:0] LEAD_MAX_US = 9'h154;

	// ****************************************************************
	// Register map (byte addresses) and reset values
	// ****************************************************************
	localparam logic [7:0] ADDR_AMP_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_LEAD_TIME = 8'h04;
	localparam logic [7:0] ADDR_ANT_SELECT = 8'h08;
	localparam logic [7:0] ADDR_DIV_A_LEVEL = 8'h0c;
	localparam logic [7:0] ADDR_DIV_B_LEVEL = 8'h10;
	localparam logic [7:0] ADDR_WAIT_OFFSET = 8'h14;
	localparam logic [7:0] ADDR_CCA_THRESHOLD = 8'h18;
	localparam logic [7:0] ADDR_CCA_OFFSET = 8'h1c;
	localparam logic [7:0] ADDR_RSSI_OFFSET = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_EFFECTIVE = 8'h28;
	localparam logic [7:0] ADDR_RX_LEVEL = 8'h2c;
	localparam logic [7:0] ADDR_REPORT = 8'h30;

	localparam logic [8:0] LEAD_RST = 9'h12c;
	localparam logic [8:0] CCA_THR_RST = 9'h1aa;
	localparam logic [4:0] OFFSET_RST = 5'h00;
	localparam logic [4:0] OFFSET_MAX = 5'h1f;
	localparam logic [9:0] RX_LEVEL_RST = 10'h3a6;
	localparam logic [7:0] WAIT_GAIN_BASE = 8'h28;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int STAT_MODE_LSB = 8;
	localparam int STAT_CFG_LSB = 12;
	localparam int HI_FIELD_LSB = 16;

	localparam int PIN_DIV_A = 0;
	localparam int PIN_SW_A = 1;
	localparam int PIN_SW_B = 2;
	localparam int PIN_DIV_B = 3;
	localparam int PIN_AMP = 4;

	// ****************************************************************
	// Radio modes
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_RX = 2'b00,
		MODE_CCA = 2'b01,
		MODE_LEAD = 2'b10,
		MODE_TX = 2'b11
	} rffc_mode_t;

endpackage

// ### rtl/rffc_offset_calc.sv
// Gain offset arithmetic for thresholds and receive waiting gain.
`timescale 1ns/1ps

module rffc_offset_calc #(
	parameter int TW = 10,
	parameter int OW = 5,
	parameter int GW = 8
) (
	input wire logic [8:0] cca_thr_i,
	input wire logic [OW-1:0] cca_off_i,
	input wire logic [TW-1:0] rx_base_i,
	input wire logic [OW-1:0] wait_off_i,
	input wire logic [GW-1:0] gain_base_i,
	output logic [TW-1:0] cca_eff_o,
	output logic [TW-1:0] rx_eff_o,
	output logic [GW-1:0] wait_gain_o
);

	// ****************************************************************
	// Parameter checks
	// ****************************************************************
	if (TW < 10 || OW >= TW || OW >= GW)
	begin : g_chk
		$error("rffc_offset_calc: widths too narrow");
	end

	// ****************************************************************
	// Sums
	// ****************************************************************
	// The sums do not saturate; the offsets are limited to 31 dB, so the
	// antenna threshold range of -256 to 255 dBm cannot wrap in 10 bits.
	assign cca_eff_o = {{(TW-9){cca_thr_i[8]}}, cca_thr_i} + {{(TW-OW){1'b0}}, cca_off_i};
	assign rx_eff_o = rx_base_i + {{(TW-OW){1'b0}}, wait_off_i};
	assign wait_gain_o = gain_base_i - {{(GW-OW){1'b0}}, wait_off_i};

endmodule

// ### rtl/rffc_top.sv
// RF front-end pin control, CCA decision and LNA offset handling behind APB.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - Amp enable pin high in transmit, low in receive when enable is 1.
// - Amp lead time accepts 1 to 340 us; other writes are refused.
// - Amp pin rises the lead time before the frame start pulse.
// - Select 0 gives switch A high in TX; select 1 inverts it.
// - Switch B drives the inverse of switch A; both stay undriven until select is written.
// - Diversity output A holds its written level in all modes.
// - Diversity output B holds its written level in all modes.
// - Internal CCA threshold is antenna threshold plus CCA offset.
// - Before transmit, measured power above threshold blocks the frame.
// - Received signals with RSSI below the level threshold are discarded.
// - Waiting gain offset lowers waiting gain and raises level threshold.
// - Reported RSSI and ED are reduced by the RSSI offset.
module rffc_top #(
	parameter int CYC_PER_US = rffc_pkg::CYC_PER_US
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic tx_req_i,
	input wire logic tx_done_i,
	input wire logic rssi_valid_i,
	input wire logic [9:0] rssi_i,
	output logic frame_start_o,
	output logic cca_busy_o,
	output logic cca_clear_o,
	output logic rx_accept_o,
	output logic rx_discard_o,
	output logic [9:0] rssi_report_o,
	output logic [9:0] ed_report_o,
	output logic [7:0] rx_wait_gain_o,
	input wire logic diversity_out_a_i,
	output logic diversity_out_a_o,
	output logic diversity_out_a_oe_n_o,
	input wire logic rf_switch_ctl_a_i,
	output logic rf_switch_ctl_a_o,
	output logic rf_switch_ctl_a_oe_n_o,
	input wire logic rf_switch_ctl_b_i,
	output logic rf_switch_ctl_b_o,
	output logic rf_switch_ctl_b_oe_n_o,
	input wire logic diversity_out_b_i,
	output logic diversity_out_b_o,
	output logic diversity_out_b_oe_n_o,
	input wire logic amp_enable_pin_i,
	output logic amp_enable_pin_o,
	output logic amp_enable_pin_oe_n_o
);

	if (CYC_PER_US < 1 || CYC_PER_US > 256)
	begin : g_chk
		$error("rffc_top: CYC_PER_US must be 1 to 256");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		rffc_pkg::rffc_mode_t mode;
		logic amp_en;
		logic [8:0] lead;
		logic sel;
		logic sel_cfg;
		logic div_a;
		logic div_a_cfg;
		logic div_b;
		logic div_b_cfg;
		logic [4:0] wait_off;
		logic [8:0] cca_thr;
		logic [4:0] cca_off;
		logic [4:0] rssi_off;
		logic [9:0] rx_base;
		logic [7:0] sub_cnt;
		logic [8:0] us_cnt;
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		logic [4:0] pin_lvl;
		logic [4:0] pin_out;
		logic [4:0] pin_oe_n;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic frame_start;
		logic cca_busy;
		logic cca_clear;
		logic rx_accept;
		logic rx_discard;
		logic [9:0] rssi_rep;
		logic [9:0] ed_rep;
		logic [7:0] wait_gain;
		logic [9:0] cca_eff;
		logic [9:0] rx_eff;
	} rffc_state_t;

	rffc_state_t st_r;
	rffc_state_t st_nxt;
	logic [9:0] cca_eff_w;
	logic [9:0] rx_eff_w;
	logic [7:0] wait_gain_w;
	logic [9:0] rssi_adj;
	logic tx_phase;

	rffc_offset_calc #(
		.TW(10),
		.OW(5),
		.GW(8)
	) u_calc (
		.cca_thr_i(st_r.cca_thr),
		.cca_off_i(st_r.cca_off),
		.rx_base_i(st_r.rx_base),
		.wait_off_i(st_r.wait_off),
		.gain_base_i(rffc_pkg::WAIT_GAIN_BASE),
		.cca_eff_o(cca_eff_w),
		.rx_eff_o(rx_eff_w),
		.wait_gain_o(wait_gain_w)
	);

	assign rssi_adj = rssi_i - {5'h00, st_r.rssi_off};
	assign tx_phase = (st_r.mode == rffc_pkg::MODE_LEAD) || (st_r.mode == rffc_pkg::MODE_TX);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		logic setup;
		logic access;
		logic known;
		logic wr_ok;
		logic n_tx;
		logic [31:0] rdata;
		setup = psel_i && !penable_i;
		access = psel_i && penable_i && st_r.pready;
		known = 1'b1;
		wr_ok = 1'b0;
		n_tx = 1'b0;
		rdata = 32'h0000_0000;
		st_nxt = st_r;
		st_nxt.frame_start = 1'b0;
		st_nxt.cca_busy = 1'b0;
		st_nxt.cca_clear = 1'b0;
		st_nxt.rx_accept = 1'b0;
		st_nxt.rx_discard = 1'b0;
		st_nxt.cca_eff = cca_eff_w;
		st_nxt.rx_eff = rx_eff_w;
		st_nxt.wait_gain = wait_gain_w;

		// Pin levels: a change counts once the second and third stages agree.
		st_nxt.s1 = {amp_enable_pin_i, diversity_out_b_i, rf_switch_ctl_b_i,
			rf_switch_ctl_a_i, diversity_out_a_i};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.pin_lvl = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.pin_lvl & (st_r.s2 ^ st_r.s3));

		// Register decode, shared by setup (answer) and access (commit).
		unique case (paddr_i)
			rffc_pkg::ADDR_AMP_ENABLE:
			begin
				rdata[0] = st_r.amp_en;
				wr_ok = pwdata_i[31:1] == 31'h0;
			end
			rffc_pkg::ADDR_LEAD_TIME:
			begin
				rdata[8:0] = st_r.lead;
				wr_ok = pwdata_i[31:9] == 23'h0 && pwdata_i[8:0] >= rffc_pkg::LEAD_MIN_US
					&& pwdata_i[8:0] <= rffc_pkg::LEAD_MAX_US;
			end
			rffc_pkg::ADDR_ANT_SELECT:
			begin
				rdata[0] = st_r.sel;
				wr_ok = pwdata_i[31:1] == 31'h0;
			end
			rffc_pkg::ADDR_DIV_A_LEVEL:
			begin
				rdata[0] = st_r.div_a;
				wr_ok = pwdata_i[31:1] == 31'h0;
			end
			rffc_pkg::ADDR_DIV_B_LEVEL:
			begin
				rdata[0] = st_r.div_b;
				wr_ok = pwdata_i[31:1] == 31'h0;
			end
			rffc_pkg::ADDR_WAIT_OFFSET:
			begin
				rdata[4:0] = st_r.wait_off;
				wr_ok = pwdata_i[31:5] == 27'h0;
			end
			rffc_pkg::ADDR_CCA_THRESHOLD:
			begin
				rdata[8:0] = st_r.cca_thr;
				wr_ok = pwdata_i[31:9] == 23'h0;
			end
			rffc_pkg::ADDR_CCA_OFFSET:
			begin
				rdata[4:0] = st_r.cca_off;
				wr_ok = pwdata_i[31:5] == 27'h0;
			end
			rffc_pkg::ADDR_RSSI_OFFSET:
			begin
				rdata[4:0] = st_r.rssi_off;
				wr_ok = pwdata_i[31:5] == 27'h0;
			end
			rffc_pkg::ADDR_RX_LEVEL:
			begin
				rdata[9:0] = st_r.rx_base;
				wr_ok = pwdata_i[31:10] == 22'h0;
			end
			rffc_pkg::ADDR_STATUS:
			begin
				rdata[4:0] = st_r.pin_lvl;
				rdata[rffc_pkg::STAT_MODE_LSB +: 2] = st_r.mode;
				rdata[rffc_pkg::STAT_CFG_LSB +: 4] = {st_r.div_b_cfg, st_r.div_a_cfg,
					st_r.sel_cfg, st_r.amp_en};
			end
			rffc_pkg::ADDR_EFFECTIVE:
			begin
				rdata[9:0] = st_r.cca_eff;
				rdata[rffc_pkg::HI_FIELD_LSB +: 10] = st_r.rx_eff;
			end
			rffc_pkg::ADDR_REPORT:
			begin
				rdata[9:0] = st_r.rssi_rep;
				rdata[rffc_pkg::HI_FIELD_LSB +: 10] = st_r.ed_rep;
			end
			default:
			begin
				known = 1'b0;
			end
		endcase

		st_nxt.pready = setup;
		if (setup)
		begin
			st_nxt.pslverr = !known || (pwrite_i && !wr_ok);
			st_nxt.prdata = pwrite_i ? 32'h0000_0000 : rdata;
		end
		if (access && pwrite_i && wr_ok)
		begin
			unique case (paddr_i)
				rffc_pkg::ADDR_AMP_ENABLE: st_nxt.amp_en = pwdata_i[0];
				rffc_pkg::ADDR_LEAD_TIME: st_nxt.lead = pwdata_i[8:0];
				rffc_pkg::ADDR_ANT_SELECT:
				begin
					st_nxt.sel = pwdata_i[0];
					st_nxt.sel_cfg = 1'b1;
				end
				rffc_pkg::ADDR_DIV_A_LEVEL:
				begin
					st_nxt.div_a = pwdata_i[0];
					st_nxt.div_a_cfg = 1'b1;
				end
				rffc_pkg::ADDR_DIV_B_LEVEL:
				begin
					st_nxt.div_b = pwdata_i[0];
					st_nxt.div_b_cfg = 1'b1;
				end
				rffc_pkg::ADDR_WAIT_OFFSET: st_nxt.wait_off = pwdata_i[4:0];
				rffc_pkg::ADDR_CCA_THRESHOLD: st_nxt.cca_thr = pwdata_i[8:0];
				rffc_pkg::ADDR_CCA_OFFSET: st_nxt.cca_off = pwdata_i[4:0];
				rffc_pkg::ADDR_RSSI_OFFSET: st_nxt.rssi_off = pwdata_i[4:0];
				rffc_pkg::ADDR_RX_LEVEL: st_nxt.rx_base = pwdata_i[9:0];
				default: st_nxt.rx_base = st_r.rx_base;
			endcase
		end

		// Radio sequence.
		unique case (st_r.mode)
			rffc_pkg::MODE_RX:
			begin
				if (rssi_valid_i)
				begin
					st_nxt.rssi_rep = rssi_adj;
					st_nxt.rx_discard = $signed(rssi_i) < $signed(st_r.rx_eff);
					st_nxt.rx_accept = !($signed(rssi_i) < $signed(st_r.rx_eff));
				end
				if (tx_req_i)
				begin
					st_nxt.mode = rffc_pkg::MODE_CCA;
				end
			end
			rffc_pkg::MODE_CCA:
			begin
				if (rssi_valid_i)
				begin
					st_nxt.ed_rep = rssi_adj;
					if ($signed(rssi_i) > $signed(st_r.cca_eff))
					begin
						st_nxt.cca_busy = 1'b1;
						st_nxt.mode = rffc_pkg::MODE_RX;
					end
					else
					begin
						st_nxt.cca_clear = 1'b1;
						if (st_r.amp_en)
						begin
							st_nxt.mode = rffc_pkg::MODE_LEAD;
							st_nxt.us_cnt = st_r.lead;
							st_nxt.sub_cnt = 8'(CYC_PER_US - 1);
						end
						else
						begin
							n_tx = 1'b1;
						end
					end
				end
			end
			rffc_pkg::MODE_LEAD:
			begin
				// Amp is on for lead * CYC_PER_US cycles before the frame starts.
				if (st_r.sub_cnt == 8'h00)
				begin
					st_nxt.sub_cnt = 8'(CYC_PER_US - 1);
					st_nxt.us_cnt = st_r.us_cnt - 9'h001;
					n_tx = st_r.us_cnt == 9'h001;
				end
				else
				begin
					st_nxt.sub_cnt = st_r.sub_cnt - 8'h01;
				end
			end
			rffc_pkg::MODE_TX:
			begin
				if (tx_done_i)
				begin
					st_nxt.mode = rffc_pkg::MODE_RX;
				end
			end
		endcase
		if (n_tx)
		begin
			st_nxt.mode = rffc_pkg::MODE_TX;
			st_nxt.frame_start = 1'b1;
		end

		// Pins follow the next mode so that they stand with the mode itself.
		n_tx = (st_nxt.mode == rffc_pkg::MODE_LEAD) || (st_nxt.mode == rffc_pkg::MODE_TX);
		st_nxt.pin_out[rffc_pkg::PIN_AMP] = n_tx;
		st_nxt.pin_oe_n[rffc_pkg::PIN_AMP] = !st_nxt.amp_en;
		st_nxt.pin_out[rffc_pkg::PIN_SW_A] = n_tx ^ st_nxt.sel;
		st_nxt.pin_out[rffc_pkg::PIN_SW_B] = !(n_tx ^ st_nxt.sel);
		st_nxt.pin_oe_n[rffc_pkg::PIN_SW_A] = !st_nxt.sel_cfg;
		st_nxt.pin_oe_n[rffc_pkg::PIN_SW_B] = !st_nxt.sel_cfg;
		st_nxt.pin_out[rffc_pkg::PIN_DIV_A] = st_nxt.div_a;
		st_nxt.pin_oe_n[rffc_pkg::PIN_DIV_A] = !st_nxt.div_a_cfg;
		st_nxt.pin_out[rffc_pkg::PIN_DIV_B] = st_nxt.div_b;
		st_nxt.pin_oe_n[rffc_pkg::PIN_DIV_B] = !st_nxt.div_b_cfg;
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= '0;
			st_r.lead <= rffc_pkg::LEAD_RST;
			st_r.cca_thr <= rffc_pkg::CCA_THR_RST;
			st_r.rx_base <= rffc_pkg::RX_LEVEL_RST;
			st_r.cca_eff <= {rffc_pkg::CCA_THR_RST[8], rffc_pkg::CCA_THR_RST};
			st_r.rx_eff <= rffc_pkg::RX_LEVEL_RST;
			st_r.wait_gain <= rffc_pkg::WAIT_GAIN_BASE;
			st_r.pin_oe_n <= 5'h1f;
			st_r.wait_off <= rffc_pkg::OFFSET_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata_o = st_r.prdata;
	assign pready_o = st_r.pready;
	assign pslverr_o = st_r.pslverr;
	assign frame_start_o = st_r.frame_start;
	assign cca_busy_o = st_r.cca_busy;
	assign cca_clear_o = st_r.cca_clear;
	assign rx_accept_o = st_r.rx_accept;
	assign rx_discard_o = st_r.rx_discard;
	assign rssi_report_o = st_r.rssi_rep;
	assign ed_report_o = st_r.ed_rep;
	assign rx_wait_gain_o = st_r.wait_gain;
	assign diversity_out_a_o = st_r.pin_out[rffc_pkg::PIN_DIV_A];
	assign diversity_out_a_oe_n_o = st_r.pin_oe_n[rffc_pkg::PIN_DIV_A];
	assign rf_switch_ctl_a_o = st_r.pin_out[rffc_pkg::PIN_SW_A];
	assign rf_switch_ctl_a_oe_n_o = st_r.pin_oe_n[rffc_pkg::PIN_SW_A];
	assign rf_switch_ctl_b_o = st_r.pin_out[rffc_pkg::PIN_SW_B];
	assign rf_switch_ctl_b_oe_n_o = st_r.pin_oe_n[rffc_pkg::PIN_SW_B];
	assign diversity_out_b_o = st_r.pin_out[rffc_pkg::PIN_DIV_B];
	assign diversity_out_b_oe_n_o = st_r.pin_oe_n[rffc_pkg::PIN_DIV_B];
	assign amp_enable_pin_o = st_r.pin_out[rffc_pkg::PIN_AMP];
	assign amp_enable_pin_oe_n_o = st_r.pin_oe_n[rffc_pkg::PIN_AMP];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [16:0] lead_cyc;
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			lead_cyc <= 17'h00000;
		else if (st_r.mode == rffc_pkg::MODE_LEAD)
			lead_cyc <= lead_cyc + 17'h00001;
		else if (st_r.mode == rffc_pkg::MODE_RX)
			lead_cyc <= 17'h00000;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_amp_tx_high: assert property (st_r.amp_en && tx_phase |-> amp_enable_pin_o && !amp_enable_pin_oe_n_o) else $error("amp pin not high in transmit");
	a_amp_rx_low: assert property (st_r.amp_en && st_r.mode == rffc_pkg::MODE_RX |-> !amp_enable_pin_o) else $error("amp pin not low in receive");
	a_lead_in_range: assert property (st_r.lead >= rffc_pkg::LEAD_MIN_US && st_r.lead <= rffc_pkg::LEAD_MAX_US) else $error("lead time out of range");
	a_lead_duration: assert property (st_r.frame_start && lead_cyc != 17'h0 |-> int'(lead_cyc) == int'(st_r.lead) * CYC_PER_US) else $error("amp lead time wrong");
	a_amp_before_frame: assert property (st_r.frame_start && st_r.amp_en |-> $past(amp_enable_pin_o)) else $error("amp pin not up before frame");
	a_switch_select: assert property (st_r.sel_cfg |-> rf_switch_ctl_a_o == (tx_phase ^ st_r.sel)) else $error("switch A level wrong");
	a_switch_inverse: assert property (!rf_switch_ctl_a_oe_n_o |-> rf_switch_ctl_b_o == !rf_switch_ctl_a_o && !rf_switch_ctl_b_oe_n_o) else $error("switch B not inverse of A");
	a_div_a_fixed: assert property (st_r.div_a_cfg |-> !diversity_out_a_oe_n_o && diversity_out_a_o == st_r.div_a) else $error("diversity A level wrong");
	a_div_b_fixed: assert property (st_r.div_b_cfg && $stable(st_r.div_b) |-> $stable(diversity_out_b_o) && !diversity_out_b_oe_n_o) else $error("diversity B level moved");
	a_cca_sum: assert property ($stable(st_r.cca_thr) && $stable(st_r.cca_off) |-> st_r.cca_eff == {st_r.cca_thr[8], st_r.cca_thr} + {5'h00, st_r.cca_off}) else $error("effective CCA threshold wrong");
	a_cca_busy: assert property (st_r.mode == rffc_pkg::MODE_CCA && rssi_valid_i && $signed(rssi_i) > $signed(st_r.cca_eff) |=> cca_busy_o && st_r.mode == rffc_pkg::MODE_RX ##1 !frame_start_o) else $error("busy channel not blocked");
	a_cca_clear: assert property (st_r.mode == rffc_pkg::MODE_CCA && rssi_valid_i && !($signed(rssi_i) > $signed(st_r.cca_eff)) |=> cca_clear_o && st_r.mode != rffc_pkg::MODE_RX) else $error("clear channel not taken");
	a_rx_discard: assert property (st_r.mode == rffc_pkg::MODE_RX && rssi_valid_i && $signed(rssi_i) < $signed(st_r.rx_eff) |=> rx_discard_o && !rx_accept_o) else $error("weak signal not discarded");
	a_wait_gain: assert property ($stable(st_r.wait_off) |-> rx_wait_gain_o == rffc_pkg::WAIT_GAIN_BASE - {3'h0, st_r.wait_off}) else $error("waiting gain not lowered");
	a_rssi_report: assert property (st_r.mode == rffc_pkg::MODE_RX && rssi_valid_i |=> rssi_report_o == $past(rssi_adj)) else $error("reported RSSI not offset");
	a_unwritten_undriven: assert property (!st_r.sel_cfg |-> rf_switch_ctl_a_oe_n_o && rf_switch_ctl_b_oe_n_o) else $error("unset switch pin driven");

	c_frame_with_amp: cover property (st_r.cca_clear && st_r.mode == rffc_pkg::MODE_LEAD);
	c_cca_busy: cover property (st_r.cca_busy);
	c_rx_discard: cover property (st_r.rx_discard);
	c_tx_done: cover property (st_r.mode == rffc_pkg::MODE_TX && tx_done_i);

endmodule

// ### bench/rffc_frontend_model.sv
// Far-side model of the RF switch and amplifier lines seen by the front-end block.
`timescale 1ns/1ps
module rffc_frontend_model (
	input wire logic clock_i,
	input wire logic [4:0] pin_o_i,
	input wire logic [4:0] pin_oe_n_i,
	output logic [4:0] pin_lvl_o
);
	logic [4:0] last_r = 5'h00;
	// A released line has no pull: show the inverse of its last driven level, so stale drive never passes.
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			pin_lvl_o[i] = pin_oe_n_i[i] ? ~last_r[i] : pin_o_i[i];
	end
	always_ff @(posedge clock_i)
	begin
		last_r <= (pin_o_i & ~pin_oe_n_i) | (last_r & pin_oe_n_i);
	end
endmodule

// ### bench/rf_frontend_control_test.sv
// Self-checking testbench for the RF front-end control block.
`timescale 1ns/1ps
module rf_frontend_control_test;
	localparam int CPU = 2;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic tx_req = 1'b0;
	logic tx_done = 1'b0;
	logic rssi_valid = 1'b0;
	logic [9:0] rssi = 10'h000;
	logic fstart, busy, clear, acc, disc;
	logic [9:0] rrep, erep;
	logic [7:0] wgain;
	logic [4:0] po, poe, plv;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	rffc_top #(.CYC_PER_US(CPU)) dut_u (.clock_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_req_i(tx_req),
		.tx_done_i(tx_done), .rssi_valid_i(rssi_valid), .rssi_i(rssi), .frame_start_o(fstart),
		.cca_busy_o(busy), .cca_clear_o(clear), .rx_accept_o(acc), .rx_discard_o(disc),
		.rssi_report_o(rrep), .ed_report_o(erep), .rx_wait_gain_o(wgain),
		.diversity_out_a_i(plv[0]), .diversity_out_a_o(po[0]), .diversity_out_a_oe_n_o(poe[0]),
		.rf_switch_ctl_a_i(plv[1]), .rf_switch_ctl_a_o(po[1]), .rf_switch_ctl_a_oe_n_o(poe[1]),
		.rf_switch_ctl_b_i(plv[2]), .rf_switch_ctl_b_o(po[2]), .rf_switch_ctl_b_oe_n_o(poe[2]),
		.diversity_out_b_i(plv[3]), .diversity_out_b_o(po[3]), .diversity_out_b_oe_n_o(poe[3]),
		.amp_enable_pin_i(plv[4]), .amp_enable_pin_o(po[4]), .amp_enable_pin_oe_n_o(poe[4]));
	rffc_frontend_model fe_u (.clock_i(clk), .pin_o_i(po), .pin_oe_n_i(poe), .pin_lvl_o(plv));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] rd;
		logic err;
		apb(a, 1'b1, d, rd, err);
		chk("pslverr", 32'(err), 32'(e));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic err;
		apb(a, 1'b0, 32'h0, v, err);
		chk("read", v, exp);
	endtask
	task automatic pulse_rssi(input logic [9:0] v);
		@(posedge clk);
		rssi <= v;
		rssi_valid <= 1'b1;
		@(posedge clk);
		rssi_valid <= 1'b0;
		@(posedge clk);
	endtask
	// Leaves the caller at the edge that samples the verdict cycle.
	task automatic cca(input logic [9:0] v);
		@(posedge clk);
		tx_req <= 1'b1;
		@(posedge clk);
		tx_req <= 1'b0;
		pulse_rssi(v);
	endtask
	task automatic end_tx();
		@(posedge clk);
		tx_done <= 1'b1;
		@(posedge clk);
		tx_done <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_reset();
		chk("oe_n", 32'(poe), 32'h1f);
		chk("wait gain", 32'(wgain), 32'h28);
		rd(rffc_pkg::ADDR_LEAD_TIME, 32'h12c);
		rd(rffc_pkg::ADDR_CCA_THRESHOLD, 32'h1aa);
	endtask
	task automatic t_refuse();
		wr(rffc_pkg::ADDR_LEAD_TIME, 32'h0, 1'b1);
		wr(rffc_pkg::ADDR_LEAD_TIME, 32'h155, 1'b1);
		wr(rffc_pkg::ADDR_LEAD_TIME, 32'h154, 1'b0);
		rd(rffc_pkg::ADDR_LEAD_TIME, 32'h154);
		wr(rffc_pkg::ADDR_AMP_ENABLE, 32'h2, 1'b1);
		wr(rffc_pkg::ADDR_CCA_THRESHOLD, 32'h3aa, 1'b1);
		wr(rffc_pkg::ADDR_CCA_OFFSET, 32'h20, 1'b1);
		wr(rffc_pkg::ADDR_STATUS, 32'h0, 1'b1);
		wr(8'hfc, 32'h0, 1'b1);
	endtask
	task automatic t_amp_frame();
		int n;
		wr(rffc_pkg::ADDR_AMP_ENABLE, 32'h1, 1'b0);
		wr(rffc_pkg::ADDR_LEAD_TIME, 32'h3, 1'b0);
		wr(rffc_pkg::ADDR_ANT_SELECT, 32'h0, 1'b0);
		cca(10'h39c);
		chk("clear", 32'(clear), 32'h1);
		chk("amp lead", 32'({po[4], poe[4]}), 32'h2);
		chk("switches tx", 32'(po[2:1]), 32'h1);
		chk("div oe_n", 32'({poe[3], poe[0]}), 32'h3);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (fstart !== 1'b1 && n < 100);
		chk("lead cycles", 32'(n), 32'(3 * CPU));
		end_tx();
		chk("amp rx", 32'({po[4], poe[4]}), 32'h0);
		chk("switches rx", 32'(po[2:1]), 32'h2);
	endtask
	task automatic t_sel1_busy();
		wr(rffc_pkg::ADDR_AMP_ENABLE, 32'h0, 1'b0);
		wr(rffc_pkg::ADDR_ANT_SELECT, 32'h1, 1'b0);
		cca(10'h3f6);
		chk("busy", 32'({busy, fstart}), 32'h2);
		chk("amp off", 32'(poe[4]), 32'h1);
		cca(10'h39c);
		chk("clear start", 32'({clear, fstart}), 32'h3);
		chk("switches tx1", 32'(po[2:1]), 32'h2);
		end_tx();
		chk("switches rx1", 32'(po[2:1]), 32'h1);
	endtask
	task automatic t_div();
		for (int l = 0; l < 2; l++)
		begin
			wr(rffc_pkg::ADDR_DIV_A_LEVEL, 32'(l), 1'b0);
			wr(rffc_pkg::ADDR_DIV_B_LEVEL, 32'(1 - l), 1'b0);
			cca(10'h39c);
			chk("div a", 32'({po[0], poe[0]}), 32'(l * 2));
			chk("div b", 32'({po[3], poe[3]}), 32'((1 - l) * 2));
			end_tx();
			chk("div rx", 32'({po[3], po[0]}), 32'((1 - l) * 2 + l));
		end
		repeat (4) @(posedge clk);
		rd(rffc_pkg::ADDR_STATUS, 32'h0000e013);
	endtask
	task automatic t_offsets();
		wr(rffc_pkg::ADDR_CCA_THRESHOLD, 32'h1aa, 1'b0);
		wr(rffc_pkg::ADDR_CCA_OFFSET, 32'h11, 1'b0);
		wr(rffc_pkg::ADDR_RSSI_OFFSET, 32'h11, 1'b0);
		rd(rffc_pkg::ADDR_EFFECTIVE, 32'h03a603bb);
		cca(10'h3bb);
		chk("at threshold", 32'(clear), 32'h1);
		chk("ed report", 32'(erep), 32'h3aa);
		end_tx();
		cca(10'h3bc);
		chk("above threshold", 32'(busy), 32'h1);
	endtask
	task automatic t_rx();
		wr(rffc_pkg::ADDR_WAIT_OFFSET, 32'hd, 1'b0);
		repeat (2) @(posedge clk);
		chk("wait gain", 32'(wgain), 32'h1b);
		rd(rffc_pkg::ADDR_EFFECTIVE, 32'h03b303bb);
		pulse_rssi(10'h3b2);
		chk("discard", 32'({disc, acc}), 32'h2);
		pulse_rssi(10'h3b3);
		chk("accept", 32'({disc, acc}), 32'h1);
		chk("rssi report", 32'(rrep), 32'h3a2);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// The cycle ceiling is well above the roughly 150 cycles the scenarios need.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_refuse();
		t_amp_frame();
		t_sel1_busy();
		t_div();
		t_offsets();
		t_rx();
		wrap_up();
	end
endmodule
